// *** rtl/ccddc_top.sv ***
// digitizer control, output gating, resets and black-level calibration
//
// Behaviour
// - gain code 0..767 gives code/768*36 dB
// - codes 768 and above hold gain at 36 dB
// - direct amp input bit swaps sampler for the two test inputs
// - polarity low tracks on clock high, polarity high inverts it
// - low power puts six-bit result on upper bus lines
// - low power keeps latency and forces calibration hold
// - direct converter input bit routes converter pins to converter
// - power down when pin high or bit set
// - power down stops analog, holds calibration, floats bus
// - four partial power-down bits for dacs, front end, converter
// - bus drivers on only when enable bit and pin are high
// - output enable touches drivers only, calibration keeps running
// - power-on reset loads defaults into every register
// - writing reset bit resets chip, bit clears itself shortly
// - reset pin high holds chip in reset
// - calibration uses optical-black pixels of each line
// - calibration data clipped to 511, bus data unclipped
// - averager size 4..512 by 3-bit code, default 128, spans lines
// - average minus target steers offset dacs down or up
// - fine accumulator steps; overflow re-centres fine, moves coarse
// - coarse accumulator 9 bits, fine accumulator 10 bits
// - after iteration clear averager, wait programmed lines
`timescale 1ns/1ps
module ccddc_top
  import ccddc_pkg::*;
#(
  parameter int DATA_W = 12
) (
  // clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              rst_in,
  // apb slave
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [7:0]        paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic                   pready_out,
  output logic [31:0]            prdata_out,
  output logic                   pslverr_out,
  // device pins
  input  wire logic              power_down_pin_in,
  input  wire logic              output_enable_pin_in,
  input  wire logic              reset_pin_in,
  input  wire logic              conversion_clock_in,
  // converter result stream and line timing
  input  wire logic              conv_valid_in,
  input  wire logic [DATA_W-1:0] conv_data_in,
  input  wire logic              conv_over_in,
  input  wire logic              ob_window_in,
  input  wire logic              line_end_in,
  // output bus
  output logic [DATA_W-1:0]      output_bus_out,
  output logic                   overrange_out,
  output logic                   output_bus_oe_out,
  // analog controls
  output logic [11:0]            gain_db_x64_out,
  output logic                   amp_test_input_sel_out,
  output logic                   converter_direct_sel_out,
  output logic                   converter_track_out,
  output logic                   analog_on_out,
  output logic                   front_end_on_out,
  output logic                   converter_on_out,
  output logic                   utility_dac0_on_out,
  output logic                   utility_dac1_on_out,
  output logic [8:0]             coarse_offset_dac_out,
  output logic [9:0]             fine_offset_dac_out
);
  if (DATA_W != 12) begin : g_width_check
    $error("output bus must be 12 bits");
  end

  // register file
  logic [9:0]          gain_r;
  logic [7:0]          offset_target_r;
  logic [CTRL_W-1:0]   ctrl_r;
  logic [3:0]          cal_cfg_r;
  logic [11:0]         wait_line_count_r;
  logic [1:0]          soft_rst_cnt_r;
  logic                chip_rst;
  logic                bus_write;
  logic                bus_access;
  logic                addr_ok;
  logic [31:0]         rd_mux;

  // software reset pulse spans the chip reset for a fixed number of cycles
  assign chip_rst   = reset_pin_in | (soft_rst_cnt_r != 2'h0);
  assign bus_access = psel_in & penable_in & ~pready_out;
  assign bus_write  = psel_in & penable_in & pready_out & pwrite_in & ~pslverr_out;
  assign addr_ok    = paddr_in <= ADDR_AVG && paddr_in[1:0] == 2'h0;

  logic [8:0]  coarse_r;
  logic [9:0]  fine_r;
  logic [8:0]  avg_r;

  always_comb begin
    case (paddr_in)
      ADDR_GAIN:   rd_mux = {22'h0, gain_r};
      ADDR_OFFSET: rd_mux = {24'h0, offset_target_r};
      ADDR_CTRL:   rd_mux = {22'h0, ctrl_r};
      ADDR_CAL:    rd_mux = {28'h0, cal_cfg_r};
      ADDR_WAIT:   rd_mux = {20'h0, wait_line_count_r};
      ADDR_RESET:  rd_mux = {31'h0, soft_rst_cnt_r != 2'h0};
      ADDR_COARSE: rd_mux = {23'h0, coarse_r};
      ADDR_FINE:   rd_mux = {22'h0, fine_r};
      ADDR_AVG:    rd_mux = {23'h0, avg_r};
      default:     rd_mux = 32'h0;
    endcase
  end

  // one wait state: answer comes in the second access cycle
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= 32'h0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= bus_access;
      pslverr_out <= bus_access & ~addr_ok;
      prdata_out  <= (bus_access & ~pwrite_in) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      soft_rst_cnt_r <= 2'h0;
    end else if (bus_write && paddr_in == ADDR_RESET && pwdata_in[0]) begin
      soft_rst_cnt_r <= 2'(SOFT_RST_CYC);
    end else if (soft_rst_cnt_r != 2'h0) begin
      soft_rst_cnt_r <= soft_rst_cnt_r - 2'h1;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in || chip_rst) begin
      gain_r            <= GAIN_RST;
      offset_target_r   <= OFFSET_RST;
      ctrl_r            <= CTRL_RST;
      cal_cfg_r         <= {1'b0, AVG_RST};
      wait_line_count_r <= WAIT_RST;
    end else if (bus_write) begin
      if (paddr_in == ADDR_GAIN)   gain_r            <= pwdata_in[9:0];
      if (paddr_in == ADDR_OFFSET) offset_target_r   <= pwdata_in[7:0];
      if (paddr_in == ADDR_CTRL)   ctrl_r            <= pwdata_in[CTRL_W-1:0];
      if (paddr_in == ADDR_CAL)    cal_cfg_r         <= pwdata_in[3:0];
      if (paddr_in == ADDR_WAIT)   wait_line_count_r <= pwdata_in[11:0];
    end
  end

  // mode decode
  logic        power_down;
  logic        bus_enable;
  logic        cal_hold;
  logic [9:0]  gain_eff;
  logic [11:0] gain_db_nxt;

  assign power_down  = power_down_pin_in | ctrl_r[CB_POWER_DOWN];
  assign bus_enable  = ctrl_r[CB_OUT_EN] & output_enable_pin_in & ~power_down;
  // output enable deliberately absent from hold: the loop runs with the bus floating
  assign cal_hold    = cal_cfg_r[CALB_HOLD] | ctrl_r[CB_LOW_POWER] | power_down;
  assign gain_eff    = (gain_r >= GAIN_CODE_MAX) ? GAIN_CODE_MAX : gain_r;
  assign gain_db_nxt = 12'(gain_eff * GAIN_MULT);

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      gain_db_x64_out          <= 12'h000;
      amp_test_input_sel_out   <= 1'b0;
      converter_direct_sel_out <= 1'b0;
      converter_track_out      <= 1'b0;
      analog_on_out            <= 1'b0;
      front_end_on_out         <= 1'b0;
      converter_on_out         <= 1'b0;
      utility_dac0_on_out      <= 1'b0;
      utility_dac1_on_out      <= 1'b0;
      output_bus_oe_out        <= 1'b0;
    end else begin
      gain_db_x64_out          <= gain_db_nxt;
      amp_test_input_sel_out   <= ctrl_r[CB_DIRECT_AMP];
      converter_direct_sel_out <= ctrl_r[CB_DIRECT_CNV];
      converter_track_out      <= conversion_clock_in ^ ctrl_r[CB_CLK_POL];
      analog_on_out            <= ~power_down;
      front_end_on_out         <= ~power_down & ~ctrl_r[CB_FE_OFF] & ~ctrl_r[CB_DIRECT_CNV];
      converter_on_out         <= ~power_down & ~ctrl_r[CB_CNV_OFF];
      utility_dac0_on_out      <= ~power_down & ~ctrl_r[CB_DAC0_OFF];
      utility_dac1_on_out      <= ~power_down & ~ctrl_r[CB_DAC1_OFF];
      output_bus_oe_out        <= bus_enable;
    end
  end

  // output bus: full-scale data, not the clipped copy
  logic [DATA_W-1:0] bus_nxt;
  assign bus_nxt = ctrl_r[CB_LOW_POWER] ? {conv_data_in[DATA_W-1:LP_BITS], {LP_BITS{1'b0}}} : conv_data_in;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      output_bus_out <= '0;
      overrange_out  <= 1'b0;
    end else if (conv_valid_in) begin
      output_bus_out <= bus_nxt;
      overrange_out  <= conv_over_in;
    end
  end

  // calibration datapath
  ccddc_cal_state_type state_r;
  ccddc_cal_state_type state_nxt;
  logic [8:0]  clip_pix;
  logic [18:0] sum_r;
  logic [9:0]  pix_cnt_r;
  logic [11:0] line_cnt_r;
  logic [9:0]  avg_target;
  logic [3:0]  avg_shift;
  logic        ob_pixel;
  logic        avg_done;
  logic [8:0]  avg_nxt;
  logic [9:0]  diff;
  logic        step_down;
  logic        step_up;
  logic        wait_done;

  // only values above the clip level are altered
  assign clip_pix   = (conv_data_in > DATA_W'(CLIP_MAX)) ? CLIP_MAX : conv_data_in[8:0];
  assign ob_pixel   = conv_valid_in & ob_window_in & ~cal_hold & (state_r == CAL_AVG);
  // four bits: code 7 plus the minimum shift would wrap in three
  assign avg_shift  = 4'(cal_cfg_r[2:0]) + 4'(AVG_SHIFT_MIN);
  assign avg_target = 10'(1) << avg_shift;
  assign avg_done   = ob_pixel && (pix_cnt_r + 10'h1 == avg_target);
  assign avg_nxt    = 9'((sum_r + 19'(clip_pix)) >> avg_shift);
  assign diff       = {1'b0, avg_r} - {2'b00, offset_target_r};
  assign step_down  = ~diff[9] & (diff != 10'h0);
  assign step_up    = diff[9];
  assign wait_done  = line_cnt_r >= wait_line_count_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CAL_AVG:  if (avg_done) state_nxt = CAL_UPD;
      CAL_UPD:  if (!cal_hold) state_nxt = CAL_WAIT;
      CAL_WAIT: if (wait_done) state_nxt = CAL_AVG;
      default:  state_nxt = CAL_AVG;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in || chip_rst) begin
      state_r    <= CAL_AVG;
      sum_r      <= 19'h0;
      pix_cnt_r  <= 10'h0;
      line_cnt_r <= 12'h000;
      avg_r      <= 9'h000;
    end else begin
      state_r <= state_nxt;
      if (state_r == CAL_UPD) begin
        sum_r      <= 19'h0;
        pix_cnt_r  <= 10'h0;
        line_cnt_r <= 12'h000;
      end else if (avg_done) begin
        avg_r <= avg_nxt;
      end else if (ob_pixel) begin
        sum_r     <= sum_r + 19'(clip_pix);
        pix_cnt_r <= pix_cnt_r + 10'h1;
      end
      if (state_r == CAL_WAIT && line_end_in && !wait_done) begin
        line_cnt_r <= line_cnt_r + 12'h001;
      end
    end
  end

  // accumulators: single-count fine steps keep the loop slow and artifact free
  logic fine_ovf;
  logic fine_unf;
  logic do_update;
  assign do_update = (state_r == CAL_UPD) & ~cal_hold;
  assign fine_ovf  = do_update & step_up & (fine_r == FINE_MAX);
  assign fine_unf  = do_update & step_down & (fine_r == 10'h000);

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in || chip_rst) begin
      coarse_r <= COARSE_MID;
      fine_r   <= FINE_MID;
    end else if (fine_ovf) begin
      fine_r   <= FINE_MID;
      if (coarse_r != COARSE_MAX) coarse_r <= coarse_r + 9'h001;
    end else if (fine_unf) begin
      fine_r   <= FINE_MID;
      if (coarse_r != 9'h000) coarse_r <= coarse_r - 9'h001;
    end else if (do_update && step_up) begin
      fine_r <= fine_r + 10'h001;
    end else if (do_update && step_down) begin
      fine_r <= fine_r - 10'h001;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      coarse_offset_dac_out <= COARSE_MID;
      fine_offset_dac_out   <= FINE_MID;
    end else begin
      coarse_offset_dac_out <= coarse_r;
      fine_offset_dac_out   <= fine_r;
    end
  end

  // checks
  property p_gain_clamp;
    @(posedge sys_clk_in) disable iff (rst_in)
    gain_r >= GAIN_CODE_MAX |=> gain_db_x64_out == 12'(GAIN_CODE_MAX * GAIN_MULT);
  endproperty
  a_gain_clamp: assert property (p_gain_clamp) else $error("gain not held at max");

  property p_gain_linear;
    @(posedge sys_clk_in) disable iff (rst_in)
    gain_r < GAIN_CODE_MAX |=> gain_db_x64_out == 12'($past(gain_r) * GAIN_MULT);
  endproperty
  a_gain_linear: assert property (p_gain_linear) else $error("gain not linear in code");

  property p_bus_gate;
    @(posedge sys_clk_in) disable iff (rst_in)
    !(ctrl_r[CB_OUT_EN] && output_enable_pin_in) |=> !output_bus_oe_out;
  endproperty
  a_bus_gate: assert property (p_bus_gate) else $error("bus driven while disabled");

  property p_pd_pin;
    @(posedge sys_clk_in) disable iff (rst_in)
    power_down_pin_in |=> !analog_on_out && !output_bus_oe_out;
  endproperty
  a_pd_pin: assert property (p_pd_pin) else $error("power down ignored");

  property p_soft_reset;
    @(posedge sys_clk_in) disable iff (rst_in)
    bus_write && paddr_in == ADDR_RESET && pwdata_in[0] && !reset_pin_in |=> chip_rst [*2] ##1 !chip_rst;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset length wrong");

  property p_low_power;
    @(posedge sys_clk_in) disable iff (rst_in)
    ctrl_r[CB_LOW_POWER] && conv_valid_in |=> output_bus_out[LP_BITS-1:0] == '0;
  endproperty
  a_low_power: assert property (p_low_power) else $error("low bits not cleared");

  property p_hold;
    @(posedge sys_clk_in) disable iff (rst_in || chip_rst)
    cal_hold |=> $stable(fine_r) && $stable(coarse_r);
  endproperty
  a_hold: assert property (p_hold) else $error("accumulator moved in hold");

  property p_fine_ovf;
    @(posedge sys_clk_in) disable iff (rst_in || chip_rst)
    fine_ovf && coarse_r != COARSE_MAX |=> fine_r == FINE_MID && coarse_r == $past(coarse_r) + 9'h001;
  endproperty
  a_fine_ovf: assert property (p_fine_ovf) else $error("fine overflow mishandled");

  property p_clip;
    @(posedge sys_clk_in) disable iff (rst_in || chip_rst)
    ob_pixel && !avg_done |=> sum_r - $past(sum_r) <= 19'(CLIP_MAX);
  endproperty
  a_clip: assert property (p_clip) else $error("clipper passed hot pixel");

  property p_track;
    @(posedge sys_clk_in) disable iff (rst_in)
    ##1 converter_track_out == ($past(conversion_clock_in) ^ $past(ctrl_r[CB_CLK_POL]));
  endproperty
  a_track: assert property (p_track) else $error("track phase wrong");

  c_fine_ovf:  cover property (@(posedge sys_clk_in) disable iff (rst_in) fine_ovf);
  c_fine_unf:  cover property (@(posedge sys_clk_in) disable iff (rst_in) fine_unf);
  c_wait_done: cover property (@(posedge sys_clk_in) disable iff (rst_in) state_r == CAL_WAIT ##1 state_r == CAL_AVG);
  c_soft_rst:  cover property (@(posedge sys_clk_in) disable iff (rst_in) soft_rst_cnt_r != 2'h0);
endmodule

// *** rtl/ccddc_pkg.sv ***
// constants, register map and types of the digitizer control block
package ccddc_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SOFT_RST_NS = 10;
  localparam int SOFT_RST_CYC = (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0] ADDR_GAIN   = 8'h00;
  localparam logic [7:0] ADDR_OFFSET = 8'h04;
  localparam logic [7:0] ADDR_CTRL   = 8'h08;
  localparam logic [7:0] ADDR_CAL    = 8'h0C;
  localparam logic [7:0] ADDR_WAIT   = 8'h10;
  localparam logic [7:0] ADDR_RESET  = 8'h14;
  localparam logic [7:0] ADDR_COARSE = 8'h18;
  localparam logic [7:0] ADDR_FINE   = 8'h1C;
  localparam logic [7:0] ADDR_AVG    = 8'h20;

  // control and calibration register bit positions
  localparam int CB_DIRECT_AMP = 0;
  localparam int CB_CLK_POL    = 1;
  localparam int CB_LOW_POWER  = 2;
  localparam int CB_DIRECT_CNV = 3;
  localparam int CB_POWER_DOWN = 4;
  localparam int CB_DAC0_OFF   = 5;
  localparam int CB_DAC1_OFF   = 6;
  localparam int CB_FE_OFF     = 7;
  localparam int CB_CNV_OFF    = 8;
  localparam int CB_OUT_EN     = 9;
  localparam int CTRL_W        = 10;
  localparam int CALB_HOLD     = 3;

  localparam logic [9:0]  GAIN_RST   = 10'h000;
  localparam logic [7:0]  OFFSET_RST = 8'h20;
  localparam logic [9:0]  CTRL_RST   = 10'h200;
  localparam logic [2:0]  AVG_RST    = 3'h5;
  localparam logic [11:0] WAIT_RST   = 12'h000;

  localparam logic [9:0]  GAIN_CODE_MAX = 10'h300;
  localparam logic [1:0]  GAIN_MULT     = 2'h3;
  localparam logic [8:0]  CLIP_MAX      = 9'h1FF;
  localparam logic [9:0]  FINE_MID      = 10'h200;
  localparam logic [9:0]  FINE_MAX      = 10'h3FF;
  localparam logic [8:0]  COARSE_MID    = 9'h100;
  localparam logic [8:0]  COARSE_MAX    = 9'h1FF;
  localparam int          AVG_SHIFT_MIN = 2;
  localparam int          LP_BITS       = 6;

  typedef enum logic [2:0] {
    CAL_AVG  = 3'b001,
    CAL_UPD  = 3'b010,
    CAL_WAIT = 3'b100
  } ccddc_cal_state_type;
endpackage

// *** verif/ccddc_sensor_model.sv ***
// sensor, timing generator and dsp side model driving the pixel stream
`timescale 1ns/1ps
module ccddc_sensor_model (
  // clock and control
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic        run_in,
  input  wire logic [11:0] px_in,
  // pixel stream
  output logic             conversion_clock_out,
  output logic             conv_valid_out,
  output logic [11:0]      conv_data_out,
  output logic             conv_over_out,
  output logic             ob_window_out,
  output logic             line_end_out
);
  logic [3:0] cnt_r;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= 4'h0;
    end else if (run_in) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // half-rate clock, 50% duty, keeps toggling in every mode; still between runs
  assign conversion_clock_out = run_in & cnt_r[0];
  assign conv_valid_out       = run_in & cnt_r[0];
  // a result is not held outside its valid beat
  assign conv_data_out        = conv_valid_out ? px_in : ~px_in;
  assign conv_over_out        = conv_valid_out & (&px_in);
  // first half of each 16-cycle line carries four black pixels
  assign ob_window_out        = run_in & ~cnt_r[3];
  assign line_end_out         = run_in & (&cnt_r);
endmodule

// *** verif/ccddc_top_tb.sv ***
// self-checking testbench of the digitizer control block
`timescale 1ns/1ps
module ccddc_top_tb;
  import ccddc_pkg::*;
  typedef struct packed {
    logic [9:0]  g;
    logic [9:0]  c;
    logic        pd;
    logic        oe;
    logic [11:0] eg;
    logic [8:0]  ef;
    logic [8:0]  m;
  } ccddc_row_type;

  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        pdp = 1'b0, oep = 1'b1, rsp = 1'b0, run = 1'b0, erv;
  logic [7:0]  pa = 8'h00;
  logic [31:0] pwd = 32'h0, rdv;
  logic [11:0] px = 12'h000, cdat, bus, gdb;
  logic        cclk, cval, cov, obw, lend, prdy, perr, ovr, boe;
  logic        asel, csel, trk, aon, feon, cvon, d0on, d1on;
  logic [31:0] prd;
  logic [8:0]  coarse_offset_dac, flg;
  logic [9:0]  fine_offset_dac, f;
  int          num_errors = 0, num_checks = 0, n;
  logic [31:0] rv [8] = '{32'h0, 32'h20, 32'h200, 32'h5, 32'h0, 32'h0, 32'h100, 32'h200};
  logic [9:0]  hc [3] = '{10'h204, 10'h200, 10'h210};
  logic [3:0]  hk [3] = '{4'h0, 4'h8, 4'h0};
  ccddc_row_type rows [9] = '{
    '{10'h000, 10'h200, 1'b0, 1'b1, 12'h000, 9'h03F, 9'h1FF},
    '{10'h0AA, 10'h201, 1'b0, 1'b1, 12'h1FE, 9'h0BF, 9'h1FF},
    '{10'h2FF, 10'h208, 1'b0, 1'b1, 12'h8FD, 9'h06F, 9'h1FF},
    '{10'h300, 10'h3E0, 1'b0, 1'b1, 12'h900, 9'h021, 9'h1FF},
    '{10'h3FF, 10'h200, 1'b0, 1'b0, 12'h900, 9'h03E, 9'h1FF},
    '{10'h000, 10'h000, 1'b0, 1'b1, 12'h000, 9'h03E, 9'h1FF},
    '{10'h000, 10'h202, 1'b0, 1'b1, 12'h000, 9'h13F, 9'h1FF},
    '{10'h000, 10'h210, 1'b0, 1'b1, 12'h000, 9'h000, 9'h0E1},
    '{10'h000, 10'h200, 1'b1, 1'b1, 12'h000, 9'h000, 9'h0E1}};

  assign flg = {trk, asel, csel, aon, feon, cvon, d0on, d1on, boe};

  always #4 clk = ~clk;

  ccddc_sensor_model ccddc_sensor_model_inst (
    .sys_clk_in(clk), .rst_in(rst), .run_in(run), .px_in(px),
    .conversion_clock_out(cclk), .conv_valid_out(cval), .conv_data_out(cdat),
    .conv_over_out(cov), .ob_window_out(obw), .line_end_out(lend));

  ccddc_top ccddc_top_inst (
    .sys_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .pready_out(prdy),
    .prdata_out(prd), .pslverr_out(perr), .power_down_pin_in(pdp),
    .output_enable_pin_in(oep), .reset_pin_in(rsp), .conversion_clock_in(cclk),
    .conv_valid_in(cval), .conv_data_in(cdat), .conv_over_in(cov),
    .ob_window_in(obw), .line_end_in(lend), .output_bus_out(bus),
    .overrange_out(ovr), .output_bus_oe_out(boe), .gain_db_x64_out(gdb),
    .amp_test_input_sel_out(asel), .converter_direct_sel_out(csel),
    .converter_track_out(trk), .analog_on_out(aon), .front_end_on_out(feon),
    .converter_on_out(cvon), .utility_dac0_on_out(d0on),
    .utility_dac1_on_out(d1on), .coarse_offset_dac_out(coarse_offset_dac),
    .fine_offset_dac_out(fine_offset_dac));

  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic timeout;
    num_errors++;
    $display("unexpected at %0t: wait ran out", $time);
    complete_run();
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (prdy !== 1'b1 && k < 20);
    rdv = prd;
    erv = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (k >= 20) timeout();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rdv, e);
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rdc(8'(4 * i), rv[i]);
    end
    apb(1'b0, 8'h24, 32'h0);
    check(erv, 1'b1);
    wr(ADDR_COARSE, 32'h55);
    rdc(ADDR_COARSE, 32'h100);
    $display("test reset values done");
    foreach (rows[i]) begin
      wr(ADDR_GAIN, rows[i].g);
      wr(ADDR_CTRL, rows[i].c);
      pdp <= rows[i].pd;
      oep <= rows[i].oe;
      cyc(3);
      check(gdb, rows[i].eg);
      check(flg & rows[i].m, rows[i].ef & rows[i].m);
    end
    pdp <= 1'b0;
    oep <= 1'b1;
    wr(ADDR_CTRL, 32'h200);
    $display("test control table done");
    // eight-pixel average spans two lines; hot pixels push the fine dac down
    wr(ADDR_CAL, 32'h1);
    px <= 12'h300;
    run <= 1'b1;
    cyc(200);
    rdc(ADDR_AVG, 32'h1FF);
    check(bus, 12'h300);
    check(fine_offset_dac < 10'h200, 1'b1);
    check(coarse_offset_dac, 9'h100);
    wr(ADDR_CTRL, 32'h0);
    cyc(4);
    f = fine_offset_dac;
    cyc(100);
    check(fine_offset_dac < f, 1'b1);
    check(boe, 1'b0);
    $display("test calibration done");
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CAL, hk[i]);
      wr(ADDR_CTRL, hc[i]);
      cyc(4);
      f = fine_offset_dac;
      cyc(100);
      check(fine_offset_dac, f);
      if (i == 0) check(bus[11:6], 6'h0C);
    end
    $display("test hold causes done");
    wr(ADDR_RESET, 32'h1);
    cyc(3);
    check(coarse_offset_dac, 9'h100);
    check(fine_offset_dac, 10'h200);
    rdc(ADDR_CTRL, 32'h200);
    rdc(ADDR_RESET, 32'h0);
    $display("test soft reset done");
    // dark pixels climb the fine dac until it wraps into the coarse one
    px <= 12'h000;
    wr(ADDR_CAL, 32'h0);
    n = 0;
    while (coarse_offset_dac === 9'h100 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20000) timeout();
    check(coarse_offset_dac, 9'h101);
    check(fine_offset_dac, 10'h200);
    $display("test fine overflow done");
    px <= 12'hFFF;
    cyc(4);
    check(ovr, 1'b1);
    check(bus, 12'hFFF);
    // largest average: 512 pixels span 128 lines
    px <= 12'h100;
    wr(ADDR_RESET, 32'h1);
    check(ovr, 1'b0);
    wr(ADDR_CAL, 32'h7);
    cyc(1000);
    rdc(ADDR_AVG, 32'h0);
    cyc(1200);
    rdc(ADDR_AVG, 32'h100);
    $display("test overrange and long average done");
    wr(ADDR_GAIN, 32'h100);
    rsp <= 1'b1;
    wr(ADDR_GAIN, 32'h5);
    cyc(2);
    check(gdb, 12'h000);
    check(coarse_offset_dac, 9'h100);
    rsp <= 1'b0;
    cyc(2);
    rdc(ADDR_GAIN, 32'h0);
    $display("test reset pin done");
    complete_run();
  end
endmodule
